// ==== rtl/quad_pkg.sv ====
package quad_pkg;
    // register byte offsets
    localparam logic [7:0] ctrl_offset      = 8'h00;
    localparam logic [7:0] preload_offset   = 8'h04;
    localparam logic [7:0] count_offset     = 8'h08;
    localparam logic [7:0] status_offset    = 8'h0c;
    localparam logic [7:0] mask_offset      = 8'h10;
    // control field positions
    localparam int decode_lsb   = 4;
    localparam int b_enable_bit = 6;
    localparam int index_lsb    = 7;
    localparam int cond_lsb     = 10;
    localparam int unused_lo    = 12;
    localparam int debounce_bit = 13;
    localparam int unused_hi    = 14;
    localparam int irq_en_bit   = 15;
    localparam logic [15:0] ctrl_reset      = 16'h0000;
    localparam logic [15:0] ctrl_write_mask = 16'hafff;
    // status bits
    localparam int equal_event_bit = 0;
    localparam int index_event_bit = 1;
    localparam logic [1:0] mask_reset = 2'h3;
    // index qualification codes
    localparam logic [2:0] index_a0_b1 = 3'h1;
    localparam logic [2:0] index_a1_b0 = 3'h2;
    localparam logic [2:0] index_a1_b1 = 3'h3;
    localparam logic [2:0] index_a0_b0 = 3'h4;
    // interrupt condition codes
    localparam logic [1:0] cond_none   = 2'h0;
    localparam logic [1:0] cond_equal  = 2'h1;
    localparam logic [1:0] cond_reload = 2'h2;
    localparam logic [1:0] cond_index  = 2'h3;
    // decode resolution codes
    localparam logic [1:0] single_edge_decode = 2'h1;
    localparam logic [1:0] double_edge_decode = 2'h2;
    localparam logic [1:0] quad_edge_decode   = 2'h3;
    // debounce timing
    localparam int clk_period_ns   = 100;
    localparam int reject_width_ns = 2500;
    // stable for more than the rejection width
    localparam int reject_cycles   = reject_width_ns / clk_period_ns + 1;
endpackage

// ==== rtl/filter_if.sv ====
`timescale 1ns/10ps
interface filter_if;
    logic       enable;
    logic [2:0] raw;
    logic [2:0] clean;
    modport ctrl (output enable, output raw, input clean);
    modport filt (input enable, input raw, output clean);
endinterface

// ==== rtl/input_debounce.sv ====
`timescale 1ns/10ps
module input_debounce #(
    parameter int count_width = 5
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // filter link
    filter_if.filt    fl
);
    wire [2:0] stable;
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_ch
            logic [count_width-1:0] cnt_q;
            logic                   stable_q;
            wire differs = fl.raw[i] != stable_q;
            wire settled = cnt_q == count_width'(quad_pkg::reject_cycles - 1);
            // accept a level only after it has held past the width
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q    <= '0;
                    stable_q <= 1'b0;
                end else if (!differs) begin
                    cnt_q <= '0; // [R16]
                end else if (settled) begin
                    cnt_q    <= '0;
                    stable_q <= fl.raw[i]; // [R11]
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
            assign stable[i] = stable_q;
        end
    endgenerate
    // bypass when disabled
    assign fl.clean = fl.enable ? stable : fl.raw; // [R10]
endmodule

// ==== rtl/quadrature_index_irq_control.sv ====
// Overview of operation
// (R1) Bits 9 to 7 qualify index: events only while index is high and A/B match the code.
// (R2) Codes 001, 010, 011, 100 need A/B of 01, 10, 11 and 00 respectively.
// (R3) Codes 000 (reset), 101, 110 and 111 disable index qualification.
// (R4) Condition field 00 selects no interrupt condition.
// (R5) Condition 01 raises an event when the counter equals the preload constant.
// (R6) Condition 10 raises an event on a qualified index and reloads the counter.
// (R7) Condition 11 raises an event on a qualified index without reloading.
// (R8) Bit 12 ignores writes and reads zero.
// (R9) Bit 14 ignores writes and reads zero.
// (R10) Bit 13 clear (reset) passes A, B and index unfiltered.
// (R11) Bit 13 set rejects pulses of at most 2.5 us on A, B and index.
// (R12) Bit 15 clear (reset) keeps the interrupt request low.
// (R13) Condition 01 holds the output active while counter equals the preload.
// (R14) Condition bit 11 holds the output active while the qualified index holds.
// (R15) The A decode field picks single, double or quad edge counting.
// (R16) The filter samples in the clock domain and accepts a level held past the width.
// (R17) Events set pending flags held until serviced; request is an unmasked flag and enable.
`timescale 1ns/10ps
module quadrature_index_irq_control #(
    parameter int count_width = 16
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // encoder
    input  wire logic        phase_a_input,
    input  wire logic        phase_b_input,
    input  wire logic        index_input,
    // outputs
    output logic             channel_out,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0]            ctrl_q;
    logic [count_width-1:0] preload_q;
    logic [count_width-1:0] count_q;
    logic [count_width-1:0] count_d;
    logic [1:0]             status_q;
    logic [1:0]             mask_q;
    logic [1:0]             ab_q;
    logic [31:0]            prdata_d;
    logic                   pready_q;
    logic                   pslverr_q;
    logic                   out_q;
    logic                   irq_q;
    logic                   qual_q;
    logic                   equal_q;

    ////////////////////////////////////////////////////////////////////
    // input filter
    filter_if fl ();
    assign fl.enable = ctrl_q[quad_pkg::debounce_bit];
    assign fl.raw    = {index_input, phase_b_input, phase_a_input};

    input_debounce #(
        .count_width(5)
    ) u_debounce (
        .pclk    (pclk),
        .presetn (presetn),
        .fl      (fl)
    );

    wire a_in   = fl.clean[0];
    wire b_in   = fl.clean[1];
    wire idx_in = fl.clean[2];

    ////////////////////////////////////////////////////////////////////
    // field decode
    wire [2:0] index_code = ctrl_q[quad_pkg::index_lsb +: 3];
    wire [1:0] cond       = ctrl_q[quad_pkg::cond_lsb +: 2];
    wire [1:0] decode     = ctrl_q[quad_pkg::decode_lsb +: 2];
    wire       b_enable   = ctrl_q[quad_pkg::b_enable_bit];
    wire       irq_enable = ctrl_q[quad_pkg::irq_en_bit];

    // index qualification
    wire match_code =
        (index_code == quad_pkg::index_a0_b1 && !a_in &&  b_in) ||
        (index_code == quad_pkg::index_a1_b0 &&  a_in && !b_in) ||
        (index_code == quad_pkg::index_a1_b1 &&  a_in &&  b_in) ||
        (index_code == quad_pkg::index_a0_b0 && !a_in && !b_in); // [R2] [R3]
    wire qualified  = idx_in && match_code; // [R1]
    wire qual_rise  = qualified && !qual_q;
    wire index_mode = cond[1];
    wire reload     = qual_rise && cond == quad_pkg::cond_reload; // [R6]
    wire idx_event  = qual_rise && index_mode; // [R6] [R7]
    wire is_equal   = count_q == preload_q;
    wire eq_mode    = cond == quad_pkg::cond_equal;
    wire eq_event   = eq_mode && is_equal && !equal_q; // [R5] [R4]

    ////////////////////////////////////////////////////////////////////
    // quadrature decoder
    wire a_edge  = a_in != ab_q[0];
    wire b_edge  = b_in != ab_q[1];
    wire a_rise  = a_edge && a_in;
    // up when a leads b
    wire up_a    = a_in != b_in;
    wire up_b    = a_in == b_in;
    wire step_1x = a_rise;
    wire step_2x = a_edge;
    wire step_4x = a_edge || (b_edge && b_enable);
    wire dir_up  = a_edge ? up_a : up_b;

    logic step;
    always_comb begin
        case (decode)
            quad_pkg::single_edge_decode: step = step_1x; // [R15]
            quad_pkg::double_edge_decode: step = step_2x; // [R15]
            quad_pkg::quad_edge_decode:   step = step_4x; // [R15]
            default:                      step = 1'b0;
        endcase
    end

    always_comb begin
        count_d = count_q;
        if (reload) begin
            count_d = preload_q; // [R6]
        end else if (step) begin
            count_d = dir_up ? count_q + 1'b1 : count_q - 1'b1; // [R7]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ab_q    <= 2'h0;
            count_q <= '0;
            qual_q  <= 1'b0;
            equal_q <= 1'b0;
        end else begin
            ab_q    <= {b_in, a_in};
            count_q <= count_d;
            qual_q  <= qualified;
            equal_q <= is_equal;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // channel output
    wire out_d = (eq_mode && is_equal) || (index_mode && qualified); // [R13] [R14]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb decode
    wire setup     = psel && !penable;
    wire access    = psel && penable;
    wire hit_ctrl  = paddr == quad_pkg::ctrl_offset;
    wire hit_pre   = paddr == quad_pkg::preload_offset;
    wire hit_cnt   = paddr == quad_pkg::count_offset;
    wire hit_stat  = paddr == quad_pkg::status_offset;
    wire hit_mask  = paddr == quad_pkg::mask_offset;
    wire mapped    = hit_ctrl || hit_pre || hit_cnt || hit_stat || hit_mask;
    wire wr_en     = access && pwrite && pready_q;
    wire rd_stat   = access && !pwrite && pready_q && hit_stat;
    wire [1:0] events = {idx_event, eq_event};

    always_comb begin
        prdata_d = 32'h0000_0000;
        if (hit_ctrl) begin
            prdata_d[15:0] = ctrl_q & quad_pkg::ctrl_write_mask; // [R8] [R9]
        end else if (hit_pre) begin
            prdata_d[count_width-1:0] = preload_q;
        end else if (hit_cnt) begin
            prdata_d[count_width-1:0] = count_q;
        end else if (hit_stat) begin
            prdata_d[1:0] = status_q;
        end else if (hit_mask) begin
            prdata_d[1:0] = mask_q;
        end
    end

    // answer one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata    <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            prdata    <= setup && !pwrite ? prdata_d : 32'h0000_0000;
        end
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= quad_pkg::ctrl_reset;
            preload_q <= '0;
            mask_q    <= quad_pkg::mask_reset;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                ctrl_q <= pwdata[15:0] & quad_pkg::ctrl_write_mask; // [R8] [R9]
            end
            if (hit_pre) begin
                preload_q <= pwdata[count_width-1:0];
            end
            if (hit_mask) begin
                mask_q <= pwdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pending flags and request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 2'h0;
            irq_q    <= 1'b0;
        end else begin
            // read clears only the bits it returned; a new event wins
            status_q <= (rd_stat ? status_q & ~prdata[1:0] : status_q) | events; // [R17]
            irq_q    <= irq_enable && |(status_q & mask_q); // [R12] [R17]
        end
    end

    assign channel_out = out_q;
    assign irq         = irq_q;
endmodule

// ==== sim/quad_asserts.sv ====
`timescale 1ns/10ps
module quad_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        phase_a_input,
    input wire logic        phase_b_input,
    input wire logic        index_input,
    input wire logic        channel_out,
    input wire logic        irq
);
    logic [15:0] ctl_q;
    wire  [2:0]  code   = ctl_q[9:7];
    wire  [1:0]  cond   = ctl_q[11:10];
    wire         deb    = ctl_q[13];
    wire         wr_ctl = psel && penable && pready && pwrite && paddr == quad_pkg::ctrl_offset;
    wire         mapped = paddr <= 8'h10 && paddr[1:0] == 2'h0;
    wire         rd_ctl = pready && !pwrite && paddr == quad_pkg::ctrl_offset;
    wire         qual   = index_input && phase_a_input && phase_b_input && code == 3'h3;
    // shadow of the control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctl_q <= 16'h0000;
        else if (wr_ctl)
            ctl_q <= pwdata[15:0] & quad_pkg::ctrl_write_mask;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_unused_bits_zero: assert property (rd_ctl |-> !prdata[14] && !prdata[12])
        else $error("unused control bits read nonzero");
    a_unmapped_err: assert property (pready |-> pslverr == !mapped)
        else $error("slave error does not match address");
    a_irq_gated: assert property (!ctl_q[15] && !$past(ctl_q[15]) |-> !irq)
        else $error("interrupt with service disabled");
    a_cond_none: assert property ((cond == 2'h0)[*3] |-> !channel_out)
        else $error("output active with no condition");
    a_code_off: assert property ((cond[1] && (code == 3'h0 || code > 3'h4))[*3]
        |-> !channel_out)
        else $error("output active with index disabled");
    a_index_low: assert property ((cond[1] && !deb && !index_input)[*3] |-> !channel_out)
        else $error("output active with index low");
    a_code_match: assert property ((cond == 2'h3 && !deb && qual)[*3]
        |-> channel_out)
        else $error("qualified index not shown");
    c_irq: cover property ($rose(irq));
    c_reload: cover property (cond == 2'h2 && channel_out);
    c_err: cover property (pready && pslverr);
endmodule
bind quadrature_index_irq_control quad_asserts u_chk (.*);

// ==== sim/quad_encoder.sv ====
`timescale 1ns/10ps
module quad_encoder (
    // clock
    input  wire logic pclk,
    // encoder lines
    output logic      phase_a,
    output logic      phase_b,
    output logic      index
);
    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
        index   = 1'b0;
    end
    // levels change just after a clock edge
    task automatic drive(input logic a, input logic b, input logic i);
        @(posedge pclk);
        phase_a <= a;
        phase_b <= b;
        index   <= i;
    endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin failures++; \
    $display("CHECK FAILED at %0t: got %0h want %0h", $time, g, x); end end
module tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        phase_a_input;
    logic        phase_b_input;
    logic        index_input;
    logic        channel_out;
    logic        irq;
    logic [31:0] r;
    logic        e;
    logic        hit;
    int          failures;
    int          checked;
    int          cycles;
    quadrature_index_irq_control u_dut (.*);
    quad_encoder u_enc (.pclk(pclk), .phase_a(phase_a_input), .phase_b(phase_b_input),
                        .index(index_input));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
        apb(1'b0, ad, 32'h0);
        `CHK(r, x)
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic give_verdict();
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(quad_pkg::ctrl_offset, 32'h0);
        rdc(quad_pkg::mask_offset, 32'h3);
        wr(quad_pkg::ctrl_offset, 32'hffff);
        rdc(quad_pkg::ctrl_offset, 32'hafff);
        apb(1'b0, 8'h40, 32'h0);
        `CHK(e, 1'b1)
        // every index code against every a/b level pair
        for (int c = 0; c < 8; c++) begin
            for (int ab = 0; ab < 4; ab++) begin
                wr(quad_pkg::ctrl_offset, 32'h8c00 | (c << 7));
                u_enc.drive(ab[1], ab[0], 1'b1);
                wt(3);
                hit = (c == 1 && ab == 1) || (c == 2 && ab == 2) ||
                      (c == 3 && ab == 3) || (c == 4 && ab == 0);
                `CHK(channel_out, hit)
                u_enc.drive(ab[1], ab[0], 1'b0);
                wt(3);
                `CHK(channel_out, 1'b0)
            end
        end
        // pending flag, mask and enable
        wr(quad_pkg::ctrl_offset, 32'h8d80);
        apb(1'b0, quad_pkg::status_offset, 32'h0);
        wt(2);
        `CHK(irq, 1'b0)
        u_enc.drive(1'b1, 1'b1, 1'b1);
        wt(3);
        `CHK(irq, 1'b1)
        rdc(quad_pkg::status_offset, 32'h2);
        wt(2);
        `CHK(irq, 1'b0)
        wr(quad_pkg::mask_offset, 32'h0);
        u_enc.drive(1'b1, 1'b1, 1'b0);
        u_enc.drive(1'b1, 1'b1, 1'b1);
        wt(3);
        `CHK(irq, 1'b0)
        rdc(quad_pkg::status_offset, 32'h2);
        wr(quad_pkg::mask_offset, 32'h3);
        wr(quad_pkg::ctrl_offset, 32'h0d80);
        u_enc.drive(1'b1, 1'b1, 1'b0);
        u_enc.drive(1'b1, 1'b1, 1'b1);
        wt(3);
        `CHK(irq, 1'b0)
        // reload on index, then no reload
        u_enc.drive(1'b0, 1'b0, 1'b0);
        wr(quad_pkg::preload_offset, 32'h5);
        wr(quad_pkg::ctrl_offset, 32'h0a00);
        u_enc.drive(1'b0, 1'b0, 1'b1);
        wt(3);
        rdc(quad_pkg::count_offset, 32'h5);
        u_enc.drive(1'b0, 1'b0, 1'b0);
        wr(quad_pkg::preload_offset, 32'h9);
        wr(quad_pkg::ctrl_offset, 32'h0e00);
        u_enc.drive(1'b0, 1'b0, 1'b1);
        wt(3);
        rdc(quad_pkg::count_offset, 32'h5);
        // counter equal to preload
        u_enc.drive(1'b0, 1'b0, 1'b0);
        wr(quad_pkg::preload_offset, 32'h6);
        apb(1'b0, quad_pkg::status_offset, 32'h0);
        wr(quad_pkg::ctrl_offset, 32'h0410);
        u_enc.drive(1'b1, 1'b0, 1'b0);
        wt(3);
        `CHK(channel_out, 1'b1)
        rdc(quad_pkg::status_offset, 32'h1);
        wr(quad_pkg::ctrl_offset, 32'h0010);
        u_enc.drive(1'b0, 1'b0, 1'b0);
        u_enc.drive(1'b1, 1'b0, 1'b0);
        wt(3);
        rdc(quad_pkg::status_offset, 32'h0);
        rdc(quad_pkg::count_offset, 32'h7);
        // debounce: 25-cycle pulse rejected, longer one taken
        wr(quad_pkg::ctrl_offset, 32'h2010);
        u_enc.drive(1'b0, 1'b0, 1'b0);
        wt(30);
        u_enc.drive(1'b1, 1'b0, 1'b0);
        wt(24);
        u_enc.drive(1'b0, 1'b0, 1'b0);
        wt(30);
        rdc(quad_pkg::count_offset, 32'h7);
        u_enc.drive(1'b1, 1'b0, 1'b0);
        wt(40);
        rdc(quad_pkg::count_offset, 32'h8);
        // four and then two counts per forward cycle
        wr(quad_pkg::ctrl_offset, 32'h0070);
        u_enc.drive(1'b1, 1'b1, 1'b0);
        u_enc.drive(1'b0, 1'b1, 1'b0);
        u_enc.drive(1'b0, 1'b0, 1'b0);
        u_enc.drive(1'b1, 1'b0, 1'b0);
        rdc(quad_pkg::count_offset, 32'hc);
        wr(quad_pkg::ctrl_offset, 32'h0020);
        u_enc.drive(1'b1, 1'b1, 1'b0);
        u_enc.drive(1'b0, 1'b1, 1'b0);
        u_enc.drive(1'b0, 1'b0, 1'b0);
        u_enc.drive(1'b1, 1'b0, 1'b0);
        rdc(quad_pkg::count_offset, 32'he);
        // reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        wt(2);
        `CHK({channel_out, irq, pready}, 3'h0)
        @(posedge pclk);
        presetn <= 1'b1;
        rdc(quad_pkg::ctrl_offset, 32'h0);
        rdc(quad_pkg::count_offset, 32'h0);
        give_verdict();
    end
endmodule
